// ==== logic/ncrp_host.sv ====
// Host sequencer that drives the flash command, address and read pins.
// Assumes flash pins are synchronous to sys_clk and the ready pin is already clean.
//
// Behaviour
// - Column is an 11-bit word index, 1056 words, in address cycles one and two.
// - Page in block is six bits starting at I/O0 of the third cycle.
// - Block index starts at bit 17; nine bits for the 512Mb part.
// - Write strobe with command latch high enters a command, both low enters data.
// - Address is four write strobes with address latch high, column bytes first.
// - Page read is 00h, four address cycles, then confirm 30h.
// - Partial page read uses 31h as the confirm code.
// - Duplicate read is 00h, address, 35h; ID read is 90h.
// - Page program is 80h then 10h; cache program 80h then 15h.
// - 85h changes input column; 85h then 10h duplicates a page.
// - Random output 05h, column, E0h moves pointer within the loaded page.
// - While busy only 70h and FFh may be issued.
// - Host never issues a command code outside the defined set.
// - Random data input and output stay within a page or quarter page; the host reads reqCount words from the column with no page limit.
// - Host waits for ready before clocking data out.
// - Erase is 60h, two row cycles, D0h; page bits are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "ncrp_regs.svh"
module ncrp_host #(
  parameter int COL_BITS = `NCRP_COL_BITS,
  parameter int PAGE_BITS = `NCRP_PAGE_BITS,
  parameter int BLOCK_BITS = `NCRP_BLOCK_BITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reqValid,
  output logic reqReady,
  input wire ncrp_pkg::ncrp_op_e reqOp,
  input wire logic [COL_BITS-1:0] reqColumn,
  input wire logic [PAGE_BITS-1:0] reqPage,
  input wire logic [BLOCK_BITS-1:0] reqBlock,
  input wire logic [COL_BITS:0] reqCount,
  output logic rdValid,
  input wire logic rdReady,
  output logic [15:0] rdData,
  output logic cmdLatch,
  output logic addrLatch,
  output logic chipSelect_n,
  output logic writeStrobe_n,
  output logic read_strobe_n,
  output logic [15:0] ioOut,
  output logic ioOe_n,
  input wire logic [15:0] ioIn,
  input wire logic ready_busy_n
);
  import ncrp_pkg::*;
  // ==========================================================================
  // Declarations
  typedef enum logic [3:0] {S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WAIT_BUSY, S_WAIT_READY,
    S_READ_LOW, S_READ_HIGH, S_PUSH} ncrp_state_e;
  localparam int PHASE = `NCRP_PHASE_CYC;
  ncrp_state_e state;
  ncrp_op_e op;
  logic [COL_BITS-1:0] column;
  logic [PAGE_BITS-1:0] page;
  logic [BLOCK_BITS-1:0] block;
  logic [COL_BITS:0] remaining;
  logic [2:0] addrIdx;
  logic [3:0] phaseCnt;
  logic strobeHigh;
  logic [15:0] captured;
  ncrp_buf_if words ();
  // ==========================================================================
  // Address cycle decode; upper lines and unused bits stay low.
  wire [26:0] fullAddr = {{(27 - 17 - BLOCK_BITS){1'b0}}, block, page, column};
  wire [7:0] addrByte0 = fullAddr[7:0];
  wire [7:0] addrByte1 = {5'h00, fullAddr[10:8]};
  wire [7:0] addrByte2 = fullAddr[18:11];
  wire [7:0] addrByte3 = {1'b0, fullAddr[25:19]};
  wire [7:0] addrByte = (addrIdx == 3'd0) ? addrByte0 :
                        (addrIdx == 3'd1) ? addrByte1 :
                        (addrIdx == 3'd2) ? addrByte2 : addrByte3;
  // Random output sends column cycles only, so the page never changes under it.
  wire [2:0] addrLast = (op == NCRP_OP_RANDOM_OUT) ? 3'd1 : 3'(`NCRP_ADDR_CYCLES - 1);
  // Program, duplicate, erase and ID codes are never selected, so this port cannot alter the array.
  wire [7:0] firstCode = (op == NCRP_OP_RANDOM_OUT) ? `NCRP_CMD_RANDOM_OUT :
                         (op == NCRP_OP_RESET) ? `NCRP_CMD_RESET : `NCRP_CMD_READ_SETUP;
  wire [7:0] secondCode = (op == NCRP_OP_RANDOM_OUT) ? `NCRP_CMD_RANDOM_OUT_CONFIRM :
                          (op == NCRP_OP_PARTIAL_READ) ? `NCRP_CMD_PARTIAL_CONFIRM :
                          `NCRP_CMD_READ_CONFIRM;
  wire phaseDone = (phaseCnt == 4'(PHASE - 1));
  // Random output needs no busy wait since the page is already loaded.
  wire needLoad = (op == NCRP_OP_PAGE_READ) || (op == NCRP_OP_PARTIAL_READ);
  // A new read is only taken while the device shows ready, so nothing but reset
  // ever reaches the pins during busy.
  wire canStart = ready_busy_n || (reqOp == NCRP_OP_RESET);
  wire take = (state == S_IDLE) && reqValid && canStart;
  assign words.valid = (state == S_PUSH);
  assign words.data = captured;
  // ==========================================================================
  // Sequencer
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      op <= NCRP_OP_PAGE_READ;
      column <= '0;
      page <= '0;
      block <= '0;
      remaining <= '0;
      addrIdx <= 3'd0;
      phaseCnt <= 4'd0;
      strobeHigh <= 1'b0;
      captured <= 16'h0000;
      reqReady <= 1'b0;
      cmdLatch <= 1'b0;
      addrLatch <= 1'b0;
      chipSelect_n <= 1'b1;
      writeStrobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      ioOut <= 16'h0000;
      ioOe_n <= 1'b1;
    end
    else
    begin
      reqReady <= 1'b0;
      phaseCnt <= phaseDone ? 4'd0 : phaseCnt + 4'd1;
      unique case (state)
        S_IDLE:
        begin
          chipSelect_n <= 1'b1;
          ioOe_n <= 1'b1;
          phaseCnt <= 4'd0;
          strobeHigh <= 1'b0;
          if (take)
          begin
            reqReady <= 1'b1;
            op <= reqOp;
            column <= reqColumn;
            page <= reqPage;
            block <= reqBlock;
            remaining <= reqCount;
            addrIdx <= 3'd0;
            chipSelect_n <= 1'b0;
            state <= S_CMD1;
          end
        end
        S_CMD1:
        begin
          // Only codes from the defined set leave this block.
          cmdLatch <= 1'b1;
          ioOe_n <= 1'b0;
          ioOut <= {8'h00, firstCode};
          if (phaseDone)
          begin
            strobeHigh <= ~strobeHigh;
            writeStrobe_n <= strobeHigh;
            if (strobeHigh)
            begin
              cmdLatch <= 1'b0;
              state <= (op == NCRP_OP_RESET) ? S_WAIT_BUSY : S_ADDR;
            end
          end
        end
        S_ADDR:
        begin
          addrLatch <= 1'b1;
          ioOut <= {8'h00, addrByte};
          if (phaseDone)
          begin
            strobeHigh <= ~strobeHigh;
            writeStrobe_n <= strobeHigh;
            if (strobeHigh)
            begin
              addrIdx <= addrIdx + 3'd1;
              if (addrIdx == addrLast)
              begin
                addrLatch <= 1'b0;
                state <= S_CMD2;
              end
            end
          end
        end
        S_CMD2:
        begin
          cmdLatch <= 1'b1;
          ioOut <= {8'h00, secondCode};
          if (phaseDone)
          begin
            strobeHigh <= ~strobeHigh;
            writeStrobe_n <= strobeHigh;
            if (strobeHigh)
            begin
              cmdLatch <= 1'b0;
              ioOe_n <= 1'b1;
              state <= needLoad ? S_WAIT_BUSY : S_READ_LOW;
            end
          end
        end
        S_WAIT_BUSY:
        begin
          // A device that goes busy only after the strobe is given one phase.
          ioOe_n <= 1'b1;
          if (phaseDone)
          begin
            state <= S_WAIT_READY;
          end
        end
        S_WAIT_READY:
        begin
          if (ready_busy_n)
          begin
            state <= (op == NCRP_OP_RESET || remaining == '0) ? S_IDLE : S_READ_LOW;
          end
        end
        S_READ_LOW:
        begin
          // The strobe is low for one full phase and the word is taken as it rises.
          if (phaseDone)
          begin
            strobeHigh <= ~strobeHigh;
            read_strobe_n <= strobeHigh;
            if (strobeHigh)
            begin
              captured <= ioIn;
              remaining <= remaining - {{COL_BITS{1'b0}}, 1'b1};
              state <= S_PUSH;
            end
          end
        end
        S_PUSH:
        begin
          // The buffer stalls the strobe, so a slow reader loses no word.
          if (words.ready)
          begin
            state <= (remaining == '0) ? S_IDLE : S_READ_HIGH;
          end
        end
        S_READ_HIGH:
        begin
          if (phaseDone)
          begin
            state <= S_READ_LOW;
          end
        end
      endcase
    end
  end
  // ==========================================================================
  // Output buffer
  logic bufValid;
  logic [15:0] bufData;
  ncrp_skid_buf #(.WIDTH(16)) outBuf (
    .sys_clk(sys_clk),
    .reset(reset),
    .inWords(words),
    .outValid(bufValid),
    .outReady(!rdValid || rdReady),
    .outData(bufData)
  );
  // Registered output stage keeps the top outputs flip-flop driven.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rdValid <= 1'b0;
      rdData <= 16'h0000;
    end
    else if (!rdValid || rdReady)
    begin
      rdValid <= bufValid;
      rdData <= bufData;
    end
  end
endmodule
`default_nettype wire

// ==== logic/ncrp_regs.svh ====
// Constants for the flash host port: command codes, address layout and pin timing.
// Assumes a 25 MHz system clock; included by the package users by bare name.
`ifndef NCRP_REGS_SVH
`define NCRP_REGS_SVH
// ==========================================================================
// Command codes
`define NCRP_CMD_READ_SETUP 8'h00
`define NCRP_CMD_READ_CONFIRM 8'h30
`define NCRP_CMD_PARTIAL_CONFIRM 8'h31
`define NCRP_CMD_DUP_READ_CONFIRM 8'h35
`define NCRP_CMD_ID_READ 8'h90
`define NCRP_CMD_PROG_SETUP 8'h80
`define NCRP_CMD_PROG_CONFIRM 8'h10
`define NCRP_CMD_CACHE_CONFIRM 8'h15
`define NCRP_CMD_COLUMN_CHANGE_IN 8'h85
`define NCRP_CMD_RANDOM_OUT 8'h05
`define NCRP_CMD_RANDOM_OUT_CONFIRM 8'he0
`define NCRP_CMD_ERASE_SETUP 8'h60
`define NCRP_CMD_ERASE_CONFIRM 8'hd0
`define NCRP_CMD_STATUS 8'h70
`define NCRP_CMD_RESET 8'hff
// ==========================================================================
// Address layout, x16 512Mb part
`define NCRP_COL_BITS 11
`define NCRP_PAGE_WORDS 1056
`define NCRP_PAGE_BITS 6
`define NCRP_BLOCK_BITS 9
`define NCRP_ADDR_CYCLES 4
// ==========================================================================
// Strobe timing: each strobe phase is a least time in ns, rounded up.
`define NCRP_CLK_NS 40
`define NCRP_PHASE_NS 40
`define NCRP_PHASE_CYC ((`NCRP_PHASE_NS + `NCRP_CLK_NS - 1) / `NCRP_CLK_NS)
`endif

// ==== logic/ncrp_pkg.sv ====
// Types shared by the flash host port modules.
// Assumes nothing of its surroundings.
package ncrp_pkg;
  typedef enum logic [1:0] {NCRP_OP_PAGE_READ, NCRP_OP_PARTIAL_READ, NCRP_OP_RANDOM_OUT,
    NCRP_OP_RESET} ncrp_op_e;
  typedef logic [15:0] ncrp_word_t;
endpackage

// ==== logic/ncrp_buf_if.sv ====
// Valid/ready word channel between the sequencer and its output buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface ncrp_buf_if;
  logic valid;
  logic ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== logic/ncrp_skid_buf.sv ====
// Two-entry buffer carrying read words from the flash pins to the user.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ncrp_skid_buf #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  ncrp_buf_if.dst inWords,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // ==========================================================================
  // Storage
  logic [WIDTH-1:0] mem [2];
  logic wrPtr;
  logic rdPtr;
  logic [1:0] count;
  wire doWrite = inWords.valid && inWords.ready;
  wire doRead = outValid && outReady;
  assign inWords.ready = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign outData = mem[rdPtr];
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'd0;
    end
    else
    begin
      if (doWrite)
      begin
        mem[wrPtr] <= inWords.data[WIDTH-1:0];
        wrPtr <= ~wrPtr;
      end
      if (doRead)
      begin
        rdPtr <= ~rdPtr;
      end
      count <= count + {1'b0, doWrite} - {1'b0, doRead};
    end
  end
endmodule
`default_nettype wire

// ==== test/ncrp_host_assertions.sv ====
// Pin and handshake checker for the flash host port.
// Assumes it is bound to ncrp_host and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ncrp_host_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic rdReady,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic chipSelect_n,
  input wire logic writeStrobe_n,
  input wire logic read_strobe_n,
  input wire logic [15:0] ioOut,
  input wire logic ioOe_n,
  input wire logic ready_busy_n
);
  logic [2:0] addrCnt;
  logic prevWe;
  wire cmdFall = cmdLatch && !writeStrobe_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Address strobes since the last command.
  always_ff @(posedge sys_clk)
  begin
    prevWe <= writeStrobe_n;
    if (reset || cmdFall)
      addrCnt <= 3'h0;
    else if (addrLatch && !writeStrobe_n && prevWe)
      addrCnt <= addrCnt + 3'h1;
  end
  a_reset_idle: assert property (disable iff (1'b0) reset |=> chipSelect_n && ioOe_n && !rdValid)
    else $error("pins not idle in reset");
  a_latch_exclusive: assert property (!(cmdLatch && addrLatch))
    else $error("both latches high");
  a_strobe_select: assert property (!writeStrobe_n || !read_strobe_n |-> !chipSelect_n && (writeStrobe_n || read_strobe_n))
    else $error("strobe without select");
  a_unused_low: assert property (addrLatch && !writeStrobe_n |-> !ioOe_n && ioOut[15:8] == 8'h00 && (addrCnt != 3'h1 || ioOut[7:3] == 5'h00) && (addrCnt != 3'h3 || !ioOut[7]))
    else $error("unused address line high");
  a_cmd_known: assert property (cmdFall |-> ioOut inside {16'h0000, 16'h0030, 16'h0031, 16'h0005, 16'h00e0, 16'h00ff})
    else $error("unknown command code");
  a_busy_cmds: assert property (cmdFall && !ready_busy_n |-> ioOut[7:0] inside {8'h70, 8'hff})
    else $error("command while busy");
  a_read_ready: assert property (!read_strobe_n |-> ready_busy_n && ioOe_n)
    else $error("read strobe while busy or driving");
  a_page_addr: assert property (cmdFall && ioOut[7:0] inside {8'h30, 8'h31} |-> addrCnt == 3'h4)
    else $error("confirm without four address cycles");
  a_column_addr: assert property (cmdFall && ioOut[7:0] == 8'he0 |-> addrCnt == 3'h2)
    else $error("column change without two cycles");
  a_ready_pulse: assert property (reqReady |=> !reqReady)
    else $error("request ready longer than one cycle");
  cover property (cmdFall && ioOut == 16'h0031);
  cover property (cmdFall && ioOut == 16'h00e0);
  cover property (rdValid && !rdReady);
endmodule
`default_nettype wire

// ==== test/ncrp_flash_model.sv ====
// Behavioural flash device for the host port bench.
// Assumes pins are sampled on sys_clk; the word read is {page[4:0], column}.
`timescale 1ns/10ps
`default_nettype none
module ncrp_flash_model #(
  parameter int BUSY_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic chipSelect_n,
  input wire logic writeStrobe_n,
  input wire logic read_strobe_n,
  input wire logic [15:0] ioOut,
  output logic [15:0] ioIn,
  output logic ready_busy_n
);
  logic prevWe, prevRe;
  logic [7:0] addrByte [4];
  logic [1:0] addrIdx;
  logic [10:0] ptr;
  logic [7:0] busyCnt;
  logic [15:0] junk;
  // The host lowers its latch on the edge that raises the strobe, so what stood
  // during the low phase is kept and applied at the rise.
  logic wCmd, wAddr;
  logic [7:0] wIo;
  wire weRise = !prevWe && writeStrobe_n && !chipSelect_n;
  wire reFall = prevRe && !read_strobe_n && !chipSelect_n;
  wire [10:0] newCol = {addrByte[1][2:0], addrByte[0]};
  assign ready_busy_n = busyCnt == 8'h00;
  // A released bus shows a changing pattern so a stale word never passes.
  assign ioIn = (!chipSelect_n && !read_strobe_n) ? {addrByte[2][4:0], ptr} : junk;
  always_ff @(posedge sys_clk)
  begin
    prevWe <= writeStrobe_n;
    prevRe <= read_strobe_n;
    junk <= junk + 16'h3b5d;
    if (!writeStrobe_n)
    begin
      wCmd <= cmdLatch;
      wAddr <= addrLatch;
      wIo <= ioOut[7:0];
    end
    if (busyCnt != 8'h00)
      busyCnt <= busyCnt - 8'h01;
    if (reset)
    begin
      ptr <= 11'h000;
      busyCnt <= 8'h00;
      addrIdx <= 2'h0;
      junk <= 16'h1234;
    end
    else if (weRise && wAddr)
    begin
      addrByte[addrIdx] <= wIo;
      addrIdx <= addrIdx + 2'h1;
    end
    else if (weRise && wCmd)
    begin
      addrIdx <= 2'h0;
      case (wIo)
        8'h30, 8'h31:
        begin
          ptr <= newCol;
          busyCnt <= BUSY_CYC[7:0];
        end
        8'he0: ptr <= newCol;
        8'hff:
        begin
          ptr <= 11'h000;
          busyCnt <= 8'h03;
        end
        default: ;
      endcase
    end
    else if (reFall && ptr != 11'd1055)
      ptr <= ptr + 11'h001;
  end
endmodule
`default_nettype wire

// ==== test/ncrp_host_bench.sv ====
// Self-checking bench for the flash host port with a device model.
// Assumes the design package and headers are compiled first.
`timescale 1ns/10ps
`default_nettype none
module ncrp_host_bench;
  import ncrp_pkg::*;
  typedef struct {ncrp_op_e op; logic [10:0] col; logic [5:0] page; logic [11:0] cnt; logic stall;} ncrp_row_s;
  logic clk = 0, rst = 1, reqValid = 0, rdReady = 1;
  ncrp_op_e reqOp = NCRP_OP_PAGE_READ;
  logic [10:0] reqColumn = 0;
  logic [5:0] reqPage = 0, page = 0;
  logic [8:0] reqBlock = 9'h155;
  logic [11:0] reqCount = 0;
  wire rdValid, reqReady, cmdLatch, addrLatch, chipSelect_n, writeStrobe_n, read_strobe_n;
  wire ioOe_n, ready_busy_n;
  wire [15:0] rdData, ioOut, ioIn;
  int fails = 0, checked = 0, cycles = 0, k;
  ncrp_row_s rows [7] = '{
    '{NCRP_OP_PAGE_READ, 11'h000, 6'h03, 12'h004, 1'b0},
    '{NCRP_OP_RANDOM_OUT, 11'h064, 6'h00, 12'h003, 1'b0},
    '{NCRP_OP_PARTIAL_READ, 11'h41a, 6'h2d, 12'h008, 1'b1},
    '{NCRP_OP_PAGE_READ, 11'h41f, 6'h11, 12'h002, 1'b0},
    '{NCRP_OP_PAGE_READ, 11'h005, 6'h3e, 12'h000, 1'b0},
    '{NCRP_OP_RANDOM_OUT, 11'h41e, 6'h00, 12'h003, 1'b0},
    '{NCRP_OP_RESET, 11'h000, 6'h00, 12'h000, 1'b0}};
  always #20 clk = ~clk;
  ncrp_host DUT (.sys_clk(clk), .reset(rst), .reqValid, .reqReady, .reqOp, .reqColumn, .reqPage,
    .reqBlock, .reqCount, .rdValid, .rdReady, .rdData, .cmdLatch, .addrLatch, .chipSelect_n,
    .writeStrobe_n, .read_strobe_n, .ioOut, .ioOe_n, .ioIn, .ready_busy_n);
  ncrp_flash_model #(.BUSY_CYC(20)) flash (.sys_clk(clk), .reset(rst), .cmdLatch, .addrLatch,
    .chipSelect_n, .writeStrobe_n, .read_strobe_n, .ioOut, .ioIn, .ready_busy_n);
  task automatic conclude();
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmpWord(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic issue(ncrp_row_s r);
    int n;
    @(posedge clk);
    reqValid <= 1'b1;
    reqOp <= r.op;
    reqColumn <= r.col;
    reqPage <= r.page;
    reqCount <= r.cnt;
    rdReady <= !r.stall;
    n = 0;
    while (reqReady !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
      fails++;
    reqValid <= 1'b0;
  endtask
  // A stalled reader forces the buffer full and the strobes to wait.
  task automatic runRow(ncrp_row_s r, logic [5:0] pg);
    int i, n;
    logic [10:0] col;
    issue(r);
    if (r.stall)
      repeat (60) @(posedge clk);
    rdReady <= 1'b1;
    for (i = 0; i < r.cnt; i++)
    begin
      n = 0;
      @(posedge clk);
      while (rdValid !== 1'b1 && n < 500)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 500)
        fails++;
      col = (r.col + i > 1055) ? 11'd1055 : 11'(r.col + i);
      cmpWord("read word", {pg[4:0], col}, rdData);
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    cmpWord("idle pins", 16'h0006, {13'h0, chipSelect_n, ioOe_n, rdValid});
    rst <= 1'b0;
    for (k = 0; k < 7; k++)
    begin
      if (rows[k].op != NCRP_OP_RANDOM_OUT)
        page = rows[k].page;
      runRow(rows[k], page);
    end
    issue('{NCRP_OP_PAGE_READ, 11'h010, 6'h07, 12'h008, 1'b0});
    repeat (30) @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    cmpWord("aborted pins", 16'h0006, {13'h0, chipSelect_n, ioOe_n, rdValid});
    rst <= 1'b0;
    runRow(rows[0], rows[0].page);
    conclude();
  end
endmodule
bind ncrp_host ncrp_host_assertions chk (.sys_clk, .reset, .reqReady, .rdValid, .rdReady, .cmdLatch,
  .addrLatch, .chipSelect_n, .writeStrobe_n, .read_strobe_n, .ioOut, .ioOe_n, .ready_busy_n);
`default_nettype wire
